// >>> mbs_pkg.sv
`default_nettype none
package mbs_pkg;
   localparam logic [7:0]  ADDR_BROADCAST   = 8'h00;
   localparam logic [7:0]  ADDR_UNIQUE_MAX  = 8'hF7;
   localparam logic [7:0]  FUNC_READ_HOLD   = 8'h03;
   localparam logic [7:0]  FUNC_WRITE_ONE   = 8'h06;
   localparam logic [7:0]  FUNC_WRITE_MANY  = 8'h10;
   localparam logic [7:0]  EXC_FLAG         = 8'h80;
   localparam logic [7:0]  EXC_ILLEGAL_FUNC = 8'h01;
   localparam logic [7:0]  EXC_ILLEGAL_ADDR = 8'h02;
   localparam logic [7:0]  EXC_ILLEGAL_VAL  = 8'h03;
   localparam logic [7:0]  EXC_DEV_FAIL     = 8'h04;
   localparam logic [15:0] MAX_READ_REGS    = 16'h007D;
   localparam logic [15:0] REG_SWITCH_POS   = 16'h03E8;
   localparam logic [15:0] REG_NORMAL_SRC   = 16'h03EA;
   localparam logic [15:0] REG_ALT_SRC      = 16'h03EC;
   localparam logic [15:0] REG_DIAG_VALID   = 16'h03ED;
   localparam logic [15:0] REG_DIAG_STATUS  = 16'h03EE;
   localparam logic [2:0]  POS_N            = 3'h1;
   localparam logic [2:0]  POS_A            = 3'h2;
   localparam logic [2:0]  POS_OFF          = 3'h4;
   localparam int          BIT_POS_OFF      = 0;
   localparam int          BIT_POS_N        = 2;
   localparam logic [7:0]  DIAG_FOUR_POLE   = 8'h0B;
   localparam logic [7:0]  DIAG_THREE_POLE  = 8'h04;
   localparam logic [15:0] CRC_INIT         = 16'hFFFF;
   localparam logic [15:0] CRC_POLY         = 16'hA001;
   localparam logic [2:0]  REQ_LEN          = 3'h6;

   typedef enum logic [2:0] {
      ST_IDLE  = 3'b000,
      ST_RECV  = 3'b001,
      ST_CHECK = 3'b010,
      ST_SEND  = 3'b011,
      ST_CRCLO = 3'b100,
      ST_CRCHI = 3'b101
   } mbs_state_e;
endpackage
`default_nettype wire

// >>> mbs_crc16.sv
`timescale 1ns/1ps
`default_nettype none
// Byte-wise CRC16 accumulator, low byte of result sent first
module mbs_crc16 (
   input  wire logic        clk,
   input  wire logic        srst,
   input  wire logic        clear,
   input  wire logic        byteValid,
   input  wire logic [7:0]  byteIn,
   output logic      [15:0] crc
);
   logic [15:0] crc_ff;
   logic [15:0] nxt_crc;

   always_comb begin
      logic [15:0] c;
      // A clear that meets a byte starts a fresh sum with that byte
      c = clear ? mbs_pkg::CRC_INIT : crc_ff;
      c = c ^ {8'h00, byteIn};
      for (int i = 0; i < 8; i++) begin
         c = c[0] ? ((c >> 1) ^ mbs_pkg::CRC_POLY) : (c >> 1);
      end
      nxt_crc = clear ? mbs_pkg::CRC_INIT : crc_ff;
      if (byteValid) begin
         nxt_crc = c;
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         crc_ff <= mbs_pkg::CRC_INIT;
      end else begin
         crc_ff <= nxt_crc;
      end
   end

   assign crc = crc_ff;
endmodule
`default_nettype wire

// >>> mbs_reg_map.sv
`timescale 1ns/1ps
`default_nettype none
// Combinational read map of the common status registers
module mbs_reg_map (
   input  wire logic [15:0] addr,
   input  wire logic [2:0]  switchPos,
   input  wire logic [1:0]  normalState,
   input  wire logic [1:0]  altState,
   input  wire logic [7:0]  diagValid,
   input  wire logic [7:0]  diagStatus,
   input  wire logic        fourPole,
   output logic      [15:0] data,
   output logic             hit
);
   logic [7:0] poleMask;

   always_comb begin
      // Bits only meaningful on four-pole builds are forced off otherwise
      poleMask = fourPole ? 8'hFF : ~mbs_pkg::DIAG_FOUR_POLE;
      data = 16'h0000;
      hit  = 1'b1;
      case (addr)
         mbs_pkg::REG_SWITCH_POS:  data = {13'h0000, switchPos};
         mbs_pkg::REG_NORMAL_SRC:  data = {14'h0000, normalState};
         mbs_pkg::REG_ALT_SRC:     data = {14'h0000, altState};
         mbs_pkg::REG_DIAG_VALID:  data = {8'h00, diagValid & poleMask};
         mbs_pkg::REG_DIAG_STATUS: data = {8'h00, diagStatus & poleMask};
         default:                  hit = 1'b0;
      endcase
   end
endmodule
`default_nettype wire

// >>> mbs_slave.sv
`timescale 1ns/1ps
`default_nettype none
module mbs_slave (
   input  wire logic        clk,
   input  wire logic        srst,
   input  wire logic [7:0]  slaveAddr,
   input  wire logic        fourPole,
   input  wire logic        deviceFault,
   input  wire logic        rxValid,
   input  wire logic [7:0]  rxByte,
   input  wire logic        rxFrameEnd,
   input  wire logic        rxCommError,
   input  wire logic        txReady,
   input  wire logic [2:0]  switchPos,
   input  wire logic [1:0]  normalState,
   input  wire logic [1:0]  altState,
   input  wire logic [7:0]  diagValid,
   input  wire logic [7:0]  diagStatus,
   output logic             txValid,
   output logic      [7:0]  txByte,
   output logic             txLast,
   output logic             exceptionSent
);
   mbs_pkg::mbs_state_e state_ff, nxt_state;
   logic [7:0]  hdr_ff [0:5];
   logic [7:0]  nxt_hdr [0:5];
   logic [3:0]  cnt_ff, nxt_cnt;
   logic        err_ff, nxt_err;
   logic [7:0]  fn_ff, nxt_fn;
   logic [7:0]  exc_ff, nxt_exc;
   logic        isExc_ff, nxt_isExc;
   logic [15:0] ptr_ff, nxt_ptr;
   logic [7:0]  left_ff, nxt_left;
   logic [1:0]  phase_ff, nxt_phase;
   logic        txValid_ff, nxt_txValid;
   logic [7:0]  txByte_ff, nxt_txByte;
   logic        txLast_ff, nxt_txLast;
   logic        excSent_ff, nxt_excSent;
   logic        crcClear, crcAdd;
   logic [15:0] crcRx, crcTx;
   logic [15:0] rdData;
   logic        rdHit, rangeOk;
   logic [15:0] reqAddr, reqCount;

   // Receive-side check; the two trailing CRC bytes bring the residue to zero
   mbs_crc16 u_crc_rx (
      .clk       (clk),
      .srst      (srst),
      .clear     (state_ff == mbs_pkg::ST_IDLE),
      .byteValid (rxValid),
      .byteIn    (rxByte),
      .crc       (crcRx)
   );

   mbs_crc16 u_crc_tx (
      .clk       (clk),
      .srst      (srst),
      .clear     (crcClear),
      .byteValid (crcAdd),
      .byteIn    (nxt_txByte),
      .crc       (crcTx)
   );

   mbs_reg_map u_map (
      .addr        (ptr_ff),
      .switchPos   (switchPos),
      .normalState (normalState),
      .altState    (altState),
      .diagValid   (diagValid),
      .diagStatus  (diagStatus),
      .fourPole    (fourPole),
      .data        (rdData),
      .hit         (rdHit)
   );

   assign reqAddr  = {hdr_ff[2], hdr_ff[3]};
   assign reqCount = {hdr_ff[4], hdr_ff[5]};

   // Every register in the requested run must exist
   always_comb begin
      logic [15:0] a;
      a = 16'h0000;
      rangeOk = 1'b1;
      for (int i = 0; i < 5; i++) begin
         a = reqAddr + 16'(i);
         if (16'(i) < reqCount) begin
            rangeOk = rangeOk & ((a == mbs_pkg::REG_SWITCH_POS) | (a == mbs_pkg::REG_NORMAL_SRC)
                      | (a == mbs_pkg::REG_ALT_SRC) | (a == mbs_pkg::REG_DIAG_VALID)
                      | (a == mbs_pkg::REG_DIAG_STATUS));
         end
      end
      if (reqCount > 16'h0005) begin
         rangeOk = 1'b0;
      end
   end

   always_comb begin
      nxt_state   = state_ff;
      nxt_cnt     = cnt_ff;
      nxt_err     = err_ff;
      nxt_fn      = fn_ff;
      nxt_exc     = exc_ff;
      nxt_isExc   = isExc_ff;
      nxt_ptr     = ptr_ff;
      nxt_left    = left_ff;
      nxt_phase   = phase_ff;
      nxt_txValid = txValid_ff;
      nxt_txByte  = txByte_ff;
      nxt_txLast  = 1'b0;
      nxt_excSent = 1'b0;
      crcClear    = 1'b0;
      crcAdd      = 1'b0;
      for (int i = 0; i < 6; i++) begin
         nxt_hdr[i] = hdr_ff[i];
      end
      case (state_ff)
         mbs_pkg::ST_IDLE: begin
            nxt_cnt = 4'h0;
            nxt_err = 1'b0;
            nxt_txValid = 1'b0;
            if (rxValid) begin
               nxt_hdr[0] = rxByte;
               nxt_cnt = 4'h1;
               nxt_state = mbs_pkg::ST_RECV;
            end
         end
         mbs_pkg::ST_RECV: begin
            if (rxValid) begin
               if (cnt_ff < 4'(mbs_pkg::REQ_LEN)) begin
                  nxt_hdr[cnt_ff[2:0]] = rxByte;
               end
               if (cnt_ff != 4'hF) begin
                  nxt_cnt = cnt_ff + 4'h1;
               end
            end
            if (rxCommError) begin
               nxt_err = 1'b1;
            end
            if (rxFrameEnd) begin
               nxt_state = mbs_pkg::ST_CHECK;
            end
         end
         mbs_pkg::ST_CHECK: begin
            nxt_state = mbs_pkg::ST_IDLE;
            nxt_fn = hdr_ff[1];
            nxt_ptr = reqAddr;
            nxt_phase = 2'h0;
            nxt_isExc = 1'b1;
            // Bad check, short frame or foreign address: stay silent
            if (!err_ff && crcRx == 16'h0000 && cnt_ff >= 4'h4
                && hdr_ff[0] == slaveAddr && hdr_ff[0] != mbs_pkg::ADDR_BROADCAST) begin
               nxt_state = mbs_pkg::ST_SEND;
               crcClear = 1'b1;
               if (deviceFault) begin
                  nxt_exc = mbs_pkg::EXC_DEV_FAIL;
               end else if (hdr_ff[1] != mbs_pkg::FUNC_READ_HOLD) begin
                  // Writes would only hit read-only or command-only registers
                  nxt_exc = mbs_pkg::EXC_ILLEGAL_FUNC;
               end else if (cnt_ff != 4'h8 || reqCount == 16'h0000 || reqCount > mbs_pkg::MAX_READ_REGS) begin
                  nxt_exc = mbs_pkg::EXC_ILLEGAL_VAL;
               end else if (!rangeOk) begin
                  nxt_exc = mbs_pkg::EXC_ILLEGAL_ADDR;
               end else begin
                  nxt_isExc = 1'b0;
                  nxt_left = reqCount[7:0];
               end
            end
         end
         mbs_pkg::ST_SEND: begin
            if (!txValid_ff || txReady) begin
               nxt_txValid = 1'b1;
               crcAdd = 1'b1;
               nxt_phase = phase_ff + 2'h1;
               if (isExc_ff) begin
                  // Address, function|0x80, code, then CRC
                  case (phase_ff)
                     2'h0: nxt_txByte = slaveAddr;
                     2'h1: nxt_txByte = fn_ff | mbs_pkg::EXC_FLAG;
                     default: begin
                        nxt_txByte = exc_ff;
                        nxt_state = mbs_pkg::ST_CRCLO;
                     end
                  endcase
               end else begin
                  case (phase_ff)
                     2'h0: nxt_txByte = slaveAddr;
                     2'h1: nxt_txByte = fn_ff;
                     2'h2: nxt_txByte = {left_ff[6:0], 1'b0};
                     default: begin
                        nxt_phase = 2'h3;
                        if (!cnt_ff[3]) begin
                           nxt_txByte = rdData[15:8];
                           nxt_cnt = 4'h8;
                        end else begin
                           nxt_txByte = rdData[7:0];
                           nxt_cnt = 4'h0;
                           nxt_ptr = ptr_ff + 16'h0001;
                           nxt_left = left_ff - 8'h01;
                           if (left_ff == 8'h01) begin
                              nxt_state = mbs_pkg::ST_CRCLO;
                           end
                        end
                     end
                  endcase
                  if (phase_ff == 2'h2) begin
                     nxt_cnt = 4'h0;
                  end
               end
            end
         end
         mbs_pkg::ST_CRCLO: begin
            if (txReady) begin
               nxt_txByte = crcTx[7:0];
               nxt_state = mbs_pkg::ST_CRCHI;
            end
         end
         mbs_pkg::ST_CRCHI: begin
            if (txReady) begin
               nxt_txByte = crcTx[15:8];
               nxt_txLast = 1'b1;
               nxt_excSent = isExc_ff;
               nxt_state = mbs_pkg::ST_IDLE;
            end
         end
         default: nxt_state = mbs_pkg::ST_IDLE;
      endcase
      if (state_ff == mbs_pkg::ST_IDLE && txValid_ff && !txReady) begin
         nxt_txValid = 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         state_ff   <= mbs_pkg::ST_IDLE;
         cnt_ff     <= 4'h0;
         err_ff     <= 1'b0;
         fn_ff      <= 8'h00;
         exc_ff     <= 8'h00;
         isExc_ff   <= 1'b0;
         ptr_ff     <= 16'h0000;
         left_ff    <= 8'h00;
         phase_ff   <= 2'h0;
         txValid_ff <= 1'b0;
         txByte_ff  <= 8'h00;
         txLast_ff  <= 1'b0;
         excSent_ff <= 1'b0;
         for (int i = 0; i < 6; i++) begin
            hdr_ff[i] <= 8'h00;
         end
      end else begin
         state_ff   <= nxt_state;
         cnt_ff     <= nxt_cnt;
         err_ff     <= nxt_err;
         fn_ff      <= nxt_fn;
         exc_ff     <= nxt_exc;
         isExc_ff   <= nxt_isExc;
         ptr_ff     <= nxt_ptr;
         left_ff    <= nxt_left;
         phase_ff   <= nxt_phase;
         txValid_ff <= nxt_txValid;
         txByte_ff  <= nxt_txByte;
         txLast_ff  <= nxt_txLast;
         excSent_ff <= nxt_excSent;
         for (int i = 0; i < 6; i++) begin
            hdr_ff[i] <= nxt_hdr[i];
         end
      end
   end

   assign txValid       = txValid_ff;
   assign txByte        = txByte_ff;
   assign txLast        = txLast_ff;
   assign exceptionSent = excSent_ff;

   chk_broadcast_silent: assert property (@(posedge clk) disable iff (srst)
      (state_ff == mbs_pkg::ST_CHECK && hdr_ff[0] == mbs_pkg::ADDR_BROADCAST) |=> state_ff == mbs_pkg::ST_IDLE)
      else $error("broadcast request answered");
   chk_error_silent: assert property (@(posedge clk) disable iff (srst)
      (state_ff == mbs_pkg::ST_CHECK && err_ff) |=> state_ff != mbs_pkg::ST_SEND)
      else $error("reply after communication error");
   chk_exc_func_bit: assert property (@(posedge clk) disable iff (srst)
      (state_ff == mbs_pkg::ST_SEND && isExc_ff && phase_ff == 2'h1 && txReady) |=> txByte == (fn_ff | 8'h80))
      else $error("exception function code lacks 0x80");
   chk_nonread_func: assert property (@(posedge clk) disable iff (srst)
      (state_ff == mbs_pkg::ST_CHECK && !deviceFault && hdr_ff[1] != 8'h03) |=> exc_ff == 8'h01 || state_ff == mbs_pkg::ST_IDLE)
      else $error("wrong code for illegal function");
   chk_fault_code: assert property (@(posedge clk) disable iff (srst)
      (state_ff == mbs_pkg::ST_CHECK && deviceFault) |=> exc_ff == 8'h04 || state_ff == mbs_pkg::ST_IDLE)
      else $error("device failure not reported");
   chk_count_limit: assert property (@(posedge clk) disable iff (srst)
      (state_ff == mbs_pkg::ST_SEND && !isExc_ff && phase_ff == 2'h0)
         |-> reqCount != 16'h0000 && reqCount <= mbs_pkg::MAX_READ_REGS && left_ff == reqCount[7:0])
      else $error("read run over 125 registers");
   chk_exc_sent_len: assert property (@(posedge clk) disable iff (srst)
      $rose(excSent_ff) |-> txLast_ff && $past(state_ff) == mbs_pkg::ST_CRCHI)
      else $error("exception frame not ended by CRC");
   chk_addr_code: assert property (@(posedge clk) disable iff (srst)
      (state_ff == mbs_pkg::ST_SEND && isExc_ff && exc_ff == 8'h02) |-> !rangeOk)
      else $error("illegal address with valid range");
endmodule
`default_nettype wire

// >>> mbs_master_model.sv
`timescale 1ns/1ps
`default_nettype none
// Modbus master on the far side of the serial link
module mbs_master_model (
   input  wire logic       clk,
   output logic            rxValid,
   output logic      [7:0] rxByte,
   output logic            rxFrameEnd,
   output logic            rxCommError,
   output logic            txReady,
   input  wire logic       txValid,
   input  wire logic [7:0] txByte,
   input  wire logic       txLast,
   input  wire logic       exceptionSent
);
   logic [7:0] reply[$];
   logic       excSeen;
   logic       lastSeen;

   initial begin
      rxValid = 1'b0;
      rxByte = 8'h5A;
      rxFrameEnd = 1'b0;
      rxCommError = 1'b0;
      txReady = 1'b1;
   end

   task automatic sendFrame(input logic [7:0] frame[$], input logic commErr);
      foreach (frame[i]) begin
         @(posedge clk);
         rxValid <= 1'b1;
         rxByte <= frame[i];
         rxCommError <= commErr && i == 1;
      end
      @(posedge clk);
      rxValid <= 1'b0;
      // Idle line no longer shows the last byte
      rxByte <= ~rxByte;
      rxCommError <= 1'b0;
      rxFrameEnd <= 1'b1;
      @(posedge clk);
      rxFrameEnd <= 1'b0;
   endtask

   // Bounded wait per request; stall holds off the first byte only
   task automatic collect(input int stall, input int limit);
      int n;
      n = 0;
      reply.delete();
      excSeen = 1'b0;
      lastSeen = 1'b0;
      txReady <= stall == 0;
      while (!lastSeen && n < limit) begin
         @(posedge clk);
         n++;
         if (txValid && txReady) begin
            reply.push_back(txByte);
            lastSeen = txLast;
            excSeen = exceptionSent;
         end else if (txValid && stall > 0) begin
            stall--;
            if (stall == 0) begin
               txReady <= 1'b1;
            end
         end
      end
   endtask
endmodule
`default_nettype wire

// >>> tb_mbs_slave.sv
`timescale 1ns/1ps
`default_nettype none
module tb_mbs_slave;
   typedef logic [7:0] mbs_byteq_t[$];
   logic        clk;
   logic        srst;
   logic [7:0]  slaveAddr;
   logic        fourPole;
   logic        deviceFault;
   logic [2:0]  switchPos;
   logic [1:0]  normalState;
   logic [1:0]  altState;
   logic [7:0]  diagValid;
   logic [7:0]  diagStatus;
   logic        rxValid;
   logic [7:0]  rxByte;
   logic        rxFrameEnd;
   logic        rxCommError;
   logic        txReady;
   logic        txValid;
   logic [7:0]  txByte;
   logic        txLast;
   logic        exceptionSent;
   logic [31:0] lfsrState;
   int          error_cnt;
   int          n_checks;
   logic [15:0] regs[5] = '{16'h3E8, 16'h3EA, 16'h3EC, 16'h3ED, 16'h3EE};
   logic [7:0]  cFn[10] = '{8'h03, 8'h03, 8'h03, 8'h03, 8'h03, 8'h03, 8'h03, 8'h06, 8'h10, 8'h2B};
   logic [15:0] cAdr[10] = '{16'h3EC, 16'h3E8, 16'h3E8, 16'h3E8, 16'h3E8, 16'h3E9, 16'h3E7, 16'h3E8, 16'h3E8, 16'h3E8};
   logic [15:0] cCnt[10] = '{16'h3, 16'h2, 16'h7D, 16'h7E, 16'h0, 16'h1, 16'h1, 16'h1, 16'h1, 16'h1};

   mbs_slave mbs_slave_inst (
      .clk, .srst, .slaveAddr, .fourPole, .deviceFault, .rxValid, .rxByte, .rxFrameEnd, .rxCommError,
      .txReady, .switchPos, .normalState, .altState, .diagValid, .diagStatus, .txValid, .txByte,
      .txLast, .exceptionSent
   );
   mbs_master_model mbs_master_model_inst (
      .clk, .rxValid, .rxByte, .rxFrameEnd, .rxCommError, .txReady, .txValid, .txByte, .txLast,
      .exceptionSent
   );

   always #2 clk = ~clk;

   function automatic logic [31:0] rnd();
      lfsrState = {lfsrState[30:0], lfsrState[31] ^ lfsrState[21] ^ lfsrState[1] ^ lfsrState[0]};
      return lfsrState;
   endfunction

   function automatic logic [15:0] crc16(input mbs_byteq_t b);
      logic [15:0] c;
      c = 16'hFFFF;
      foreach (b[i]) begin
         c = c ^ {8'h00, b[i]};
         for (int k = 0; k < 8; k++) begin
            c = c[0] ? (c >> 1) ^ 16'hA001 : c >> 1;
         end
      end
      return c;
   endfunction

   function automatic mbs_byteq_t withCrc(input mbs_byteq_t q);
      logic [15:0] c;
      c = crc16(q);
      q.push_back(c[7:0]);
      q.push_back(c[15:8]);
      return q;
   endfunction

   function automatic mbs_byteq_t mkReq(input logic [7:0] dst, input logic [7:0] fn,
                                        input logic [15:0] start, input logic [15:0] cnt);
      mbs_byteq_t q;
      q = {dst, fn, start[15:8], start[7:0], cnt[15:8], cnt[7:0]};
      return withCrc(q);
   endfunction

   function automatic logic isImpl(input logic [15:0] a);
      return a inside {16'h3E8, 16'h3EA, 16'h3EC, 16'h3ED, 16'h3EE};
   endfunction

   function automatic logic [15:0] regValue(input logic [15:0] a);
      logic [7:0] keep;
      keep = fourPole ? 8'hFF : 8'hF4;
      case (a)
         16'h3E8: return {13'h0, switchPos};
         16'h3EA: return {14'h0, normalState};
         16'h3EC: return {14'h0, altState};
         16'h3ED: return {8'h00, diagValid & keep};
         default: return {8'h00, diagStatus & keep};
      endcase
   endfunction

   function automatic mbs_byteq_t expected(input mbs_byteq_t rq, input logic commErr);
      mbs_byteq_t  rp;
      logic [15:0] start;
      logic [15:0] cnt;
      logic [15:0] v;
      logic [7:0]  code;
      rp = {};
      if (commErr || rq[0] !== slaveAddr || crc16(rq[0:$-2]) !== {rq[$], rq[$-1]}) begin
         return rp;
      end
      start = {rq[2], rq[3]};
      cnt = {rq[4], rq[5]};
      code = 8'h00;
      if (deviceFault) begin
         code = 8'h04;
      end else if (rq[1] !== 8'h03) begin
         code = 8'h01;
      end else if (rq.size() != 8 || cnt == 16'h0 || cnt > 16'h007D) begin
         code = 8'h03;
      end else begin
         for (int i = 0; i < int'(cnt); i++) begin
            if (!isImpl(start + 16'(i))) begin
               code = 8'h02;
            end
         end
      end
      rp.push_back(rq[0]);
      if (code != 8'h00) begin
         rp.push_back(rq[1] | 8'h80);
         rp.push_back(code);
      end else begin
         rp.push_back(rq[1]);
         rp.push_back({cnt[6:0], 1'b0});
         for (int i = 0; i < int'(cnt); i++) begin
            v = regValue(start + 16'(i));
            rp.push_back(v[15:8]);
            rp.push_back(v[7:0]);
         end
      end
      return withCrc(rp);
   endfunction

   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      n_checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic newStatus();
      logic [31:0] r;
      r = rnd();
      @(posedge clk);
      switchPos <= 3'h1 << (r[1:0] % 3);
      normalState <= 2'(r[3:2] % 3);
      altState <= 2'(r[5:4] % 3);
      diagValid <= r[13:6];
      diagStatus <= r[21:14];
      @(posedge clk);
   endtask

   task automatic transact(input mbs_byteq_t rq, input logic commErr, input int stall);
      mbs_byteq_t ex;
      ex = expected(rq, commErr);
      mbs_master_model_inst.sendFrame(rq, commErr);
      mbs_master_model_inst.collect(stall, ex.size() == 0 ? 30 : 60);
      check("reply length", 16'(mbs_master_model_inst.reply.size()), 16'(ex.size()));
      foreach (ex[i]) begin
         if (i < mbs_master_model_inst.reply.size()) begin
            check("reply byte", 16'(mbs_master_model_inst.reply[i]), 16'(ex[i]));
         end
      end
      if (ex.size() != 0) begin
         check("exception flag", 16'(mbs_master_model_inst.excSeen), 16'(ex[1][7]));
      end
   endtask

   task automatic summarize();
      $display("checks %0d errors %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   initial begin
      #100000;
      error_cnt++;
      summarize();
   end

   initial begin
      mbs_byteq_t  rq;
      logic [31:0] r;
      clk = 1'b0;
      srst = 1'b1;
      slaveAddr = 8'h2F;
      fourPole = 1'b1;
      deviceFault = 1'b0;
      switchPos = 3'h1;
      normalState = 2'h0;
      altState = 2'h0;
      diagValid = 8'h00;
      diagStatus = 8'h00;
      lfsrState = 32'hC7F6;
      error_cnt = 0;
      n_checks = 0;
      repeat (8) @(posedge clk);
      srst <= 1'b0;
      for (int p = 0; p < 2; p++) begin
         fourPole <= p[0];
         foreach (regs[i]) begin
            newStatus();
            transact(mkReq(slaveAddr, 8'h03, regs[i], 16'h1), 1'b0, 0);
         end
      end
      foreach (cFn[i]) begin
         newStatus();
         transact(mkReq(slaveAddr, cFn[i], cAdr[i], cCnt[i]), 1'b0, i % 3);
      end
      rq = mkReq(slaveAddr, 8'h03, 16'h3E8, 16'h1);
      rq[7] = rq[7] ^ 8'h01;
      transact(rq, 1'b0, 0);
      transact(mkReq(slaveAddr, 8'h03, 16'h3E8, 16'h1), 1'b1, 0);
      transact(mkReq(8'h00, 8'h03, 16'h3E8, 16'h1), 1'b0, 0);
      transact(mkReq(8'h00, 8'h06, 16'h3E8, 16'h1), 1'b0, 0);
      transact(mkReq(slaveAddr + 8'h01, 8'h03, 16'h3E8, 16'h1), 1'b0, 0);
      rq = {slaveAddr, 8'h03, 8'h03, 8'hE8, 8'h00, 8'h01, 8'h00};
      transact(withCrc(rq), 1'b0, 0);
      deviceFault <= 1'b1;
      newStatus();
      transact(mkReq(slaveAddr, 8'h03, 16'h3E8, 16'h1), 1'b0, 2);
      transact(mkReq(slaveAddr, 8'h06, 16'h3E8, 16'h1), 1'b0, 0);
      deviceFault <= 1'b0;
      repeat (40) begin
         r = rnd();
         slaveAddr <= 8'(r[15:8] % 247) + 8'h01;
         fourPole <= r[16];
         newStatus();
         transact(mkReq(r[19:17] == 3'h0 ? 8'h00 : slaveAddr, r[20] ? 8'h03 : r[31:24],
                        16'h3E6 + 16'(r[23:21]), 16'(r[27:25])), r[28] & r[29], 0);
      end
      summarize();
   end
endmodule
`default_nettype wire
